// ===== common/fss_regs.svh
// Register offsets, field positions and counts of the frame sync / status register bank
`ifndef FSS_REGS_SVH
`define FSS_REGS_SVH
`define FSS_OFF_SYNC 8'h7F
`define FSS_OFF_GR_AVG_HI 8'h80
`define FSS_OFF_GR_AVG_LO 8'h81
`define FSS_OFF_GB_AVG_HI 8'h82
`define FSS_OFF_GB_AVG_LO 8'h83
`define FSS_OFF_R_AVG_HI 8'h84
`define FSS_OFF_R_AVG_LO 8'h85
`define FSS_OFF_B_AVG_HI 8'h86
`define FSS_OFF_B_AVG_LO 8'h87
`define FSS_OFF_ALL_AVG_HI 8'h88
`define FSS_OFF_ALL_AVG_LO 8'h89
`define FSS_OFF_REPL_CNT 8'hA0
`define FSS_OFF_CUR_ROW 8'hA1
`define FSS_OFF_NOISE_HI 8'hA2
`define FSS_OFF_NOISE_LO 8'hA3
`define FSS_OFF_ACT_ROW_HI 8'hA4
`define FSS_OFF_ACT_ROW_LO 8'hA5
`define FSS_OFF_ACT_COL_HI 8'hA6
`define FSS_OFF_ACT_COL_LO 8'hA7
`define FSS_OFF_CPR_HI 8'hA8
`define FSS_OFF_CPR_LO 8'hA9
`define FSS_OFF_TINT_HI 8'hAA
`define FSS_OFF_TINT_LO 8'hAB
`define FSS_SYNC_ENABLE_BIT 7
`define FSS_SYNC_UPDATE_BIT 6
`define FSS_SYNC_VBLANK_BIT 5
`define FSS_SYNC_RESET 8'h00
`define FSS_NOISE_PIXELS 8'hD6
`define FSS_REPL_MAX 8'hFF
`define FSS_FRAC_BITS 4
`endif

// ===== common/fss_pkg.sv
// Types shared by the frame sync / status register bank
package fss_pkg;
  typedef enum logic [1:0] {
    FSS_GREEN_RED,
    FSS_RED,
    FSS_BLUE,
    FSS_GREEN_BLUE
  } fss_color_t;

  typedef struct packed {
    logic valid;
    logic in_roi;
    fss_color_t color;
    logic [11:0] data;
  } fss_pix_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fss_reg_req_t;

  typedef enum {
    FSS_DIV_IDLE,
    FSS_DIV_RUN
  } fss_div_state_t;
endpackage

// ===== src/fss_regbank.sv
// Frame-synchronised shadow configuration and frame statistics register bank
// Operation
// - Shadow disabled: writes go straight to active
// - Shadow enabled: hold writes until update and sync
// - Commit only at frame sync, before frame
// - Update bit requests commit, self-clears after
// - Shadow enable bit self-clears at commit
// - Reads return active value, never shadow
// - Sync bit 5 reads vertical blanking
// - Averages are 12.4 unsigned, high/low bytes
// - Separate region averages per colour plus overall
// - Averages latched at active end, refreshed 190 cycles later, always valid
// - Replaced pixel count saturates at 255
// - Current row shows row counter upper bits
// - Row zero is frame start, high is blanking
// - Dark noise variance over 214 dark pixels
// - Active rows and columns as 12 bits
// - Clocks per row 12 bits, wraps to zero
// - Integration time latched before each frame
`timescale 1ns/10ps
`include "fss_regs.svh"
module fss_regbank #(
  parameter int N_CFG = 16,
  parameter logic [7:0] CFG_BASE = 8'h00,
  parameter int CNT_W = 22,
  parameter int SUM_W = 34
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire fss_pkg::fss_reg_req_t i_req,
  output logic [7:0] o_rdata,
  output logic o_rd_valid,
  output logic [N_CFG-1:0][7:0] o_cfg_active,
  input wire logic i_frame_sync,
  input wire logic i_vblank,
  input wire fss_pkg::fss_pix_t i_pix,
  input wire logic i_active_end,
  input wire logic i_dark_valid,
  input wire logic [11:0] i_dark_data,
  input wire logic [11:0] i_black_level,
  input wire logic i_pix_replaced,
  input wire logic [10:0] i_row_cnt,
  input wire logic i_row_start,
  input wire logic [11:0] i_active_rows,
  input wire logic [11:0] i_active_cols,
  input wire logic [11:0] i_tint_ae
);
  import fss_pkg::*;

  localparam int DW = SUM_W + `FSS_FRAC_BITS;
  localparam int QW = $clog2(DW);

  function automatic logic is_cfg(input logic [7:0] a);
    return (a >= CFG_BASE) && ({1'b0, a} < ({1'b0, CFG_BASE} + 9'(N_CFG)));
  endfunction

  logic wr_sync, wr_cfg, commit;
  logic [7:0] cfg_idx;
  assign wr_sync = i_req.wr_en && (i_req.addr == `FSS_OFF_SYNC);
  assign wr_cfg = i_req.wr_en && is_cfg(i_req.addr);
  assign cfg_idx = i_req.addr - CFG_BASE;

  // Sync control bits
  logic enable_q, update_q;
  assign commit = i_frame_sync && update_q;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      {enable_q, update_q} <= 2'(`FSS_SYNC_RESET >> `FSS_SYNC_UPDATE_BIT);
    end else if (wr_sync) begin
      // A host write landing on the commit cycle wins over the self-clear
      enable_q <= i_req.wdata[`FSS_SYNC_ENABLE_BIT];
      update_q <= i_req.wdata[`FSS_SYNC_UPDATE_BIT];
    end else if (commit) begin
      enable_q <= 1'b0;
      update_q <= 1'b0;
    end
  end

  // Shadow and active copies of the configuration registers
  logic [N_CFG-1:0][7:0] shadow_q, active_q;
  logic [N_CFG-1:0] pending_q;

  genvar g;
  generate
    for (g = 0; g < N_CFG; g++) begin : g_cfg
      logic hit;
      assign hit = wr_cfg && (cfg_idx == 8'(g));
      always_ff @(posedge i_mclk) begin
        if (i_srst) begin
          shadow_q[g] <= 8'h00;
          active_q[g] <= 8'h00;
          pending_q[g] <= 1'b0;
        end else begin
          if (hit) begin
            shadow_q[g] <= i_req.wdata;
          end
          if (hit && !enable_q) begin
            active_q[g] <= i_req.wdata;
            pending_q[g] <= 1'b0;
          end else if (hit) begin
            pending_q[g] <= 1'b1;
          end else if (commit && pending_q[g]) begin
            active_q[g] <= shadow_q[g];
            pending_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  assign o_cfg_active = active_q;

  // Per-colour region accumulators, index 4 is all region pixels
  logic [4:0][SUM_W-1:0] sum_q, sum_lat_q;
  logic [4:0][CNT_W-1:0] cnt_q, cnt_lat_q;
  logic take;
  assign take = i_pix.valid && i_pix.in_roi;

  generate
    for (g = 0; g < 5; g++) begin : g_acc
      logic hit;
      assign hit = take && ((g == 4) || (i_pix.color == fss_color_t'(2'(g))));
      always_ff @(posedge i_mclk) begin
        if (i_srst || i_frame_sync) begin
          sum_q[g] <= '0;
          cnt_q[g] <= '0;
        end else if (hit) begin
          sum_q[g] <= sum_q[g] + SUM_W'(i_pix.data);
          cnt_q[g] <= cnt_q[g] + CNT_W'(1);
        end
      end
    end
  endgenerate

  // One serial divider shared by the five channels; all results publish together
  fss_div_state_t div_st_q;
  logic [2:0] ch_q;
  logic [QW-1:0] bit_q;
  logic [CNT_W:0] rem_q;
  logic [DW-1:0] quo_q;
  logic [4:0][15:0] res_q, avg_q;
  logic [DW-1:0] dividend;
  logic [CNT_W:0] rem_sh;
  logic ge;
  assign dividend = {sum_lat_q[ch_q], `FSS_FRAC_BITS'(0)};
  assign rem_sh = {rem_q[CNT_W-1:0], dividend[bit_q]};
  assign ge = rem_sh >= {1'b0, cnt_lat_q[ch_q]};

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      div_st_q <= FSS_DIV_IDLE;
      ch_q <= 3'h0;
      bit_q <= '0;
      rem_q <= '0;
      quo_q <= '0;
      sum_lat_q <= '0;
      cnt_lat_q <= '0;
      res_q <= '0;
      avg_q <= '0;
    end else begin
      case (div_st_q)
        FSS_DIV_IDLE: begin
          if (i_active_end) begin
            sum_lat_q <= sum_q;
            cnt_lat_q <= cnt_q;
            ch_q <= 3'h0;
            bit_q <= QW'(DW - 1);
            rem_q <= '0;
            quo_q <= '0;
            div_st_q <= FSS_DIV_RUN;
          end
        end
        FSS_DIV_RUN: begin
          rem_q <= ge ? rem_sh - {1'b0, cnt_lat_q[ch_q]} : rem_sh;
          quo_q[bit_q] <= ge;
          if (bit_q != '0) begin
            bit_q <= bit_q - QW'(1);
          end else begin
            // Empty region reads zero; oversized quotient saturates
            if (cnt_lat_q[ch_q] == '0) begin
              res_q[ch_q] <= 16'h0000;
            end else if (quo_q[DW-1:16] != '0) begin
              res_q[ch_q] <= 16'hFFFF;
            end else begin
              res_q[ch_q] <= {quo_q[15:1], ge};
            end
            rem_q <= '0;
            quo_q <= '0;
            bit_q <= QW'(DW - 1);
            if (ch_q == 3'h4) begin
              div_st_q <= FSS_DIV_IDLE;
            end else begin
              ch_q <= ch_q + 3'h1;
            end
          end
        end
        default: div_st_q <= FSS_DIV_IDLE;
      endcase
      // Previous averages stay readable until the whole set is ready
      if (div_st_q == FSS_DIV_RUN && ch_q == 3'h4 && bit_q == '0) begin
        avg_q <= {(cnt_lat_q[4] == '0) ? 16'h0000 :
                  (quo_q[DW-1:16] != '0) ? 16'hFFFF : {quo_q[15:1], ge}, res_q[3:0]};
      end
    end
  end

  // Replaced pixels per frame
  logic [7:0] repl_q;
  always_ff @(posedge i_mclk) begin
    if (i_srst || i_frame_sync) begin
      repl_q <= 8'h00;
    end else if (i_pix_replaced && repl_q != `FSS_REPL_MAX) begin
      repl_q <= repl_q + 8'h01;
    end
  end

  // Dark noise variance against the previous frame's black level
  logic [11:0] black_prev_q;
  logic [7:0] noise_n_q;
  logic [15:0] noise_acc_q, noise_q;
  logic [12:0] diff, mag;
  logic [25:0] sq;
  assign diff = {1'b0, i_dark_data} - {1'b0, black_prev_q};
  assign mag = diff[12] ? -diff : diff;
  assign sq = 26'(mag) * 26'(mag);

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      black_prev_q <= 12'h000;
      noise_n_q <= 8'h00;
      noise_acc_q <= 16'h0000;
      noise_q <= 16'h0000;
    end else if (i_frame_sync) begin
      black_prev_q <= i_black_level;
      noise_n_q <= 8'h00;
      noise_acc_q <= 16'h0000;
    end else if (i_dark_valid && noise_n_q != `FSS_NOISE_PIXELS) begin
      noise_acc_q <= noise_acc_q + sq[15:0];
      noise_n_q <= noise_n_q + 8'h01;
      if (noise_n_q == `FSS_NOISE_PIXELS - 8'h01) begin
        noise_q <= noise_acc_q + sq[15:0];
      end
    end
  end

  // Row position, mode sizes, clocks per row and exposure
  logic [7:0] row_q;
  logic [11:0] act_rows_q, act_cols_q, cpr_cnt_q, cpr_q, tint_q;
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      row_q <= 8'h00;
      act_rows_q <= 12'h000;
      act_cols_q <= 12'h000;
    end else begin
      row_q <= i_row_cnt[10:3];
      act_rows_q <= i_active_rows;
      act_cols_q <= i_active_cols;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cpr_cnt_q <= 12'h000;
      cpr_q <= 12'h000;
    end else if (i_row_start) begin
      cpr_q <= cpr_cnt_q + 12'h001;
      cpr_cnt_q <= 12'h000;
    end else begin
      cpr_cnt_q <= cpr_cnt_q + 12'h001;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tint_q <= 12'h000;
    end else if (i_frame_sync) begin
      tint_q <= i_tint_ae;
    end
  end

  // Read port
  logic [7:0] rd_d;
  always_comb begin
    rd_d = 8'h00;
    if (is_cfg(i_req.addr)) begin
      rd_d = active_q[cfg_idx];
    end else begin
      case (i_req.addr)
        `FSS_OFF_SYNC: rd_d = {enable_q, update_q, i_vblank, 5'h00};
        `FSS_OFF_GR_AVG_HI: rd_d = avg_q[0][15:8];
        `FSS_OFF_GR_AVG_LO: rd_d = avg_q[0][7:0];
        `FSS_OFF_R_AVG_HI: rd_d = avg_q[1][15:8];
        `FSS_OFF_R_AVG_LO: rd_d = avg_q[1][7:0];
        `FSS_OFF_B_AVG_HI: rd_d = avg_q[2][15:8];
        `FSS_OFF_B_AVG_LO: rd_d = avg_q[2][7:0];
        `FSS_OFF_GB_AVG_HI: rd_d = avg_q[3][15:8];
        `FSS_OFF_GB_AVG_LO: rd_d = avg_q[3][7:0];
        `FSS_OFF_ALL_AVG_HI: rd_d = avg_q[4][15:8];
        `FSS_OFF_ALL_AVG_LO: rd_d = avg_q[4][7:0];
        `FSS_OFF_REPL_CNT: rd_d = repl_q;
        `FSS_OFF_CUR_ROW: rd_d = row_q;
        `FSS_OFF_NOISE_HI: rd_d = noise_q[15:8];
        `FSS_OFF_NOISE_LO: rd_d = noise_q[7:0];
        `FSS_OFF_ACT_ROW_HI: rd_d = {4'h0, act_rows_q[11:8]};
        `FSS_OFF_ACT_ROW_LO: rd_d = act_rows_q[7:0];
        `FSS_OFF_ACT_COL_HI: rd_d = {4'h0, act_cols_q[11:8]};
        `FSS_OFF_ACT_COL_LO: rd_d = act_cols_q[7:0];
        `FSS_OFF_CPR_HI: rd_d = {4'h0, cpr_q[11:8]};
        `FSS_OFF_CPR_LO: rd_d = cpr_q[7:0];
        `FSS_OFF_TINT_HI: rd_d = {4'h0, tint_q[11:8]};
        `FSS_OFF_TINT_LO: rd_d = tint_q[7:0];
        default: rd_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_rdata <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rdata <= i_req.rd_en ? rd_d : o_rdata;
      o_rd_valid <= i_req.rd_en;
    end
  end

  // Checks
  sequence s_div_start;
    div_st_q == FSS_DIV_IDLE && i_active_end;
  endsequence
  sequence s_div_end;
    div_st_q == FSS_DIV_IDLE;
  endsequence

  a_bypass_direct: assert property (@(posedge i_mclk) disable iff (i_srst)
    wr_cfg && !enable_q |=> active_q[$past(cfg_idx)] == $past(i_req.wdata))
    else $error("direct write did not reach active register");
  a_shadow_hold: assert property (@(posedge i_mclk) disable iff (i_srst)
    wr_cfg && enable_q |=> active_q[$past(cfg_idx)] == $past(active_q[cfg_idx]))
    else $error("shadowed write changed active register early");
  a_commit_sync: assert property (@(posedge i_mclk) disable iff (i_srst)
    !$stable(active_q) |-> $past(wr_cfg && !enable_q) || $past(commit))
    else $error("active configuration changed outside commit");
  a_update_clear: assert property (@(posedge i_mclk) disable iff (i_srst)
    commit && !wr_sync |=> !update_q ##1 ($stable(o_cfg_active) || $past(wr_cfg)))
    else $error("update bit not cleared after commit");
  a_enable_clear: assert property (@(posedge i_mclk) disable iff (i_srst)
    commit && !wr_sync |=> !enable_q)
    else $error("shadow enable not cleared at commit");
  a_vblank_read: assert property (@(posedge i_mclk) disable iff (i_srst)
    i_req.rd_en && i_req.addr == `FSS_OFF_SYNC |=> o_rd_valid && o_rdata[5] == $past(i_vblank))
    else $error("blanking flag read wrong");
  a_repl_saturate: assert property (@(posedge i_mclk) disable iff (i_srst)
    repl_q == `FSS_REPL_MAX && !i_frame_sync |=> repl_q == `FSS_REPL_MAX)
    else $error("replaced count wrapped");
  a_row_msbs: assert property (@(posedge i_mclk) disable iff (i_srst)
    1'b1 |=> row_q == $past(i_row_cnt[10:3]))
    else $error("current row does not follow row counter");
  a_avg_publish: assert property (@(posedge i_mclk) disable iff (i_srst)
    s_div_start |=> ##[1:300] s_div_end)
    else $error("averages not published in time");
  a_cpr_wrap: assert property (@(posedge i_mclk) disable iff (i_srst)
    !i_row_start && cpr_cnt_q == 12'hFFF |=> cpr_cnt_q == 12'h000)
    else $error("clocks per row counter did not wrap");
endmodule // fss_regbank

// ===== bench/fss_host_model.sv
// Host model issuing register writes and reads on the request port
`timescale 1ns/10ps
module fss_host_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rd_valid,
  output fss_pkg::fss_reg_req_t o_req,
  output logic o_timeout
);
  import fss_pkg::*;
  initial begin
    o_req = '0;
    o_timeout = 1'b0;
  end
  // Idle address and data are inverted so a stale value never looks valid
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_req <= '{1'b1, 1'b0, a, d};
    @(posedge i_mclk);
    o_req <= '{1'b0, 1'b0, ~a, ~d};
    #1;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge i_mclk);
    o_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_mclk);
    o_req <= '{1'b0, 1'b0, ~a, 8'hff};
    n = 0;
    #1;
    while (i_rd_valid !== 1'b1 && n < 4) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    if (i_rd_valid !== 1'b1) begin
      o_timeout = 1'b1;
    end
    d = i_rdata;
  endtask
endmodule // fss_host_model

// ===== bench/fss_regbank_tb.sv
// Testbench of the frame sync and status register bank
`timescale 1ns/10ps
`include "fss_regs.svh"
module fss_regbank_tb;
  import fss_pkg::*;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  fss_reg_req_t i_req;
  logic [7:0] o_rdata;
  logic o_rd_valid;
  logic [15:0][7:0] o_cfg_active;
  logic i_frame_sync = 1'b0;
  logic i_vblank = 1'b0;
  fss_pix_t i_pix = '0;
  logic i_active_end = 1'b0;
  logic i_dark_valid = 1'b0;
  logic [11:0] i_dark_data = 12'h000;
  logic [11:0] i_black_level = 12'h010;
  logic i_pix_replaced = 1'b0;
  logic [10:0] i_row_cnt = 11'h000;
  logic i_row_start = 1'b0;
  logic [11:0] i_active_rows = 12'habc;
  logic [11:0] i_active_cols = 12'h345;
  logic [11:0] i_tint_ae = 12'h000;
  logic host_timeout;
  logic [7:0] rd;
  int n_errors = 0;
  int checks_done = 0;
  logic [15:0] avg_exp [5] = '{16'h00a8, 16'h0008, 16'h0648, 16'hffe8, 16'h41b8};
  logic [11:0] pix_val [9] = '{12'h00a, 12'h00b, 12'h064, 12'h065, 12'hfff, 12'hffe, 12'h000, 12'h001, 12'hfff};
  logic [10:0] row_in [3] = '{11'h7f8, 11'h007, 11'h628};

  always #2.5 i_mclk = ~i_mclk;

  fss_regbank fss_regbank_inst (.i_mclk(i_mclk), .i_srst(i_srst), .i_req(i_req), .o_rdata(o_rdata),
    .o_rd_valid(o_rd_valid), .o_cfg_active(o_cfg_active), .i_frame_sync(i_frame_sync), .i_vblank(i_vblank),
    .i_pix(i_pix), .i_active_end(i_active_end), .i_dark_valid(i_dark_valid), .i_dark_data(i_dark_data),
    .i_black_level(i_black_level), .i_pix_replaced(i_pix_replaced), .i_row_cnt(i_row_cnt),
    .i_row_start(i_row_start), .i_active_rows(i_active_rows), .i_active_cols(i_active_cols),
    .i_tint_ae(i_tint_ae));
  fss_host_model fss_host_model_inst (.i_mclk(i_mclk), .i_rdata(o_rdata), .i_rd_valid(o_rd_valid),
    .o_req(i_req), .o_timeout(host_timeout));

  task automatic complete_run();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    fss_host_model_inst.reg_rd(a, rd);
    check({8'h00, rd}, {8'h00, e});
  endtask
  task automatic fsync();
    @(posedge i_mclk);
    i_frame_sync <= 1'b1;
    @(posedge i_mclk);
    i_frame_sync <= 1'b0;
    #1;
  endtask
  task automatic rstart();
    @(posedge i_mclk);
    i_row_start <= 1'b1;
    @(posedge i_mclk);
    i_row_start <= 1'b0;
  endtask
  always @(posedge host_timeout) begin
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge i_mclk);
    i_srst <= 1'b0;
    #1;
    check({8'h00, o_cfg_active[3]}, 16'h0000);
    rd_chk(`FSS_OFF_SYNC, 8'h00);
    fss_host_model_inst.reg_wr(8'h03, 8'h5a);
    check({8'h00, o_cfg_active[3]}, 16'h005a);
    rd_chk(8'h03, 8'h5a);
    fss_host_model_inst.reg_wr(`FSS_OFF_SYNC, 8'h80);
    fss_host_model_inst.reg_wr(8'h03, 8'ha5);
    rd_chk(8'h03, 8'h5a);
    // Sync with the update bit clear must not commit
    fsync();
    check({8'h00, o_cfg_active[3]}, 16'h005a);
    rd_chk(`FSS_OFF_SYNC, 8'h80);
    fss_host_model_inst.reg_wr(`FSS_OFF_SYNC, 8'hc0);
    repeat (20) @(posedge i_mclk);
    #1;
    check({8'h00, o_cfg_active[3]}, 16'h005a);
    fsync();
    check({8'h00, o_cfg_active[3]}, 16'h00a5);
    rd_chk(`FSS_OFF_SYNC, 8'h00);
    rd_chk(8'h03, 8'ha5);
    @(posedge i_mclk);
    i_vblank <= 1'b1;
    rd_chk(`FSS_OFF_SYNC, 8'h20);
    fss_host_model_inst.reg_wr(8'h03, 8'h3c);
    check({8'h00, o_cfg_active[3]}, 16'h003c);
    @(posedge i_mclk);
    i_vblank <= 1'b0;
    rd_chk(`FSS_OFF_SYNC, 8'h00);
    rd_chk(8'h50, 8'h00);
    // Read-only counts ignore writes
    fss_host_model_inst.reg_wr(`FSS_OFF_ACT_ROW_LO, 8'hff);
    rd_chk(`FSS_OFF_ACT_ROW_HI, 8'h0a);
    rd_chk(`FSS_OFF_ACT_ROW_LO, 8'hbc);
    rd_chk(`FSS_OFF_ACT_COL_HI, 8'h03);
    rd_chk(`FSS_OFF_ACT_COL_LO, 8'h45);
    fsync();
    @(posedge i_mclk);
    i_pix_replaced <= 1'b1;
    repeat (300) @(posedge i_mclk);
    i_pix_replaced <= 1'b0;
    rd_chk(`FSS_OFF_REPL_CNT, 8'hff);
    for (int k = 0; k < 3; k++) begin
      @(posedge i_mclk);
      i_row_cnt <= row_in[k];
      rd_chk(`FSS_OFF_CUR_ROW, row_in[k][10:3]);
    end
    rstart();
    repeat (98) @(posedge i_mclk);
    rstart();
    rd_chk(`FSS_OFF_CPR_HI, 8'h00);
    rd_chk(`FSS_OFF_CPR_LO, 8'h64);
    rstart();
    repeat (4099) @(posedge i_mclk);
    rstart();
    rd_chk(`FSS_OFF_CPR_HI, 8'h00);
    rd_chk(`FSS_OFF_CPR_LO, 8'h05);
    @(posedge i_mclk);
    i_tint_ae <= 12'h123;
    rd_chk(`FSS_OFF_TINT_LO, 8'h00);
    fsync();
    rd_chk(`FSS_OFF_TINT_HI, 8'h01);
    rd_chk(`FSS_OFF_TINT_LO, 8'h23);
    // Two pixels per colour, then one bright pixel outside the region
    fsync();
    for (int k = 0; k < 9; k++) begin
      @(posedge i_mclk);
      i_pix <= '{1'b1, k < 8, fss_color_t'(k[2:1]), pix_val[k]};
    end
    @(posedge i_mclk);
    i_pix <= '0;
    i_active_end <= 1'b1;
    @(posedge i_mclk);
    i_active_end <= 1'b0;
    repeat (200) @(posedge i_mclk);
    for (int k = 0; k < 10; k++) begin
      fss_host_model_inst.reg_rd(`FSS_OFF_GR_AVG_HI + 8'(k), rd);
      check({8'h00, rd}, {8'h00, k[0] ? avg_exp[k / 2][7:0] : avg_exp[k / 2][15:8]});
    end
    // Only the first 214 dark pixels may count; odd ones sit below the black level
    fsync();
    for (int k = 0; k < 215; k++) begin
      @(posedge i_mclk);
      i_dark_valid <= 1'b1;
      i_dark_data <= (k >= 214) ? 12'h0ff : k[0] ? 12'h00d : 12'h013;
    end
    @(posedge i_mclk);
    i_dark_valid <= 1'b0;
    rd_chk(`FSS_OFF_NOISE_HI, 8'h07);
    rd_chk(`FSS_OFF_NOISE_LO, 8'h86);
    complete_run();
  end
endmodule // fss_regbank_tb
